// *** logic/exec_unit_defines.vh ***
// Constants for the skip, swap, table-read and exclusive-OR execution unit
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH
// Operation codes presented on opSel
`define OP_NONE 4'h0
`define OP_SWAP_NIB 4'h1
`define OP_SKZ 4'h2
`define OP_SKZA 4'h3
`define OP_SKZBIT 4'h4
`define OP_TRD_CUR 4'h5
`define OP_TRD_LAST 4'h6
`define OP_XOR_TO_ACCUM 4'h7
`define OP_XOR_MEM 4'h8
`define OP_XOR_IMM 4'h9
// Program memory geometry: 12-bit word address, 15-bit word, 8-bit table pointer
`define PADDR_W 12
`define PAGE_W 4
`define LAST_PAGE 4'hf
`define HIGH_W 7
`define LOW_BYTE 7:0
`define HIGH_PART 14:8
`define NIB_LO 3:0
`define NIB_HI 7:4
`define ZERO_BYTE 8'h00
`define ZERO_HIGH 7'h00
`define ZERO_ADDR 12'h000
`endif

// *** logic/alu_xor_swap.v ***
// Combinational data path: nibble swap, exclusive-OR and zero tests
`timescale 1ns/1ns
`include "exec_unit_defines.vh"
module alu_xor_swap (
   input wire [7:0] accIn,
   input wire [7:0] memIn,
   input wire [7:0] litIn,
   input wire useLit,
   input wire [2:0] bitSel,
   output wire [7:0] swapOut,
   output wire [7:0] xorOut,
   output wire byteZero,
   output wire bitZero,
   output wire xorZero
);
   // High nibble to low, low nibble to high
   assign swapOut = {memIn[`NIB_LO], memIn[`NIB_HI]};
   // Accumulator combined with either memory or literal
   assign xorOut = accIn ^ (useLit ? litIn : memIn);
   assign byteZero = (memIn == `ZERO_BYTE);
   assign bitZero = ~memIn[bitSel];
   assign xorZero = (xorOut == `ZERO_BYTE);
endmodule

// *** logic/skip_swap_tableread_xor_exec.v ***
// Execution unit for swap, skip-if-zero, table read and exclusive-OR instructions
// Notes on behaviour
// - Swap puts memory high nibble in accumulator low, low nibble high; no flags.
// - Byte skip: zero byte discards prefetched instruction, two cycles; else one.
// - Copy-and-skip loads accumulator; zero byte also discards next instruction.
// - Bit skip: selected bit zero discards prefetched instruction, two cycles.
// - Current-page table read: low byte to memory, high part to table latch.
// - Last-page table read: same, but from the last program page.
// - XOR with memory into accumulator; only zero flag changes.
// - XOR written back to memory byte; only zero flag changes.
// - XOR with literal into accumulator; only zero flag changes.
`timescale 1ns/1ns
`include "exec_unit_defines.vh"
module skip_swap_tableread_xor_exec (
   input wire mclk,
   input wire sys_rst,
   input wire instValid,
   input wire [3:0] opSel,
   input wire [7:0] memData,
   input wire [7:0] literal,
   input wire [2:0] bitSel,
   input wire [7:0] table_pointer,
   input wire [`PAGE_W-1:0] curPage,
   input wire [14:0] progWord,
   input wire progValid,
   output reg [7:0] accumulator,
   output reg [`HIGH_W-1:0] table_high_latch,
   output reg zeroFlag,
   output reg memWrite,
   output reg [7:0] memWdata,
   output reg progRead,
   output reg [`PADDR_W-1:0] progAddr,
   output reg discardFetch,
   output reg busy
);
   // One-hot states
   localparam ST_IDLE = 3'b001;
   localparam ST_DUMMY = 3'b010;
   localparam ST_TABLE = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   wire [7:0] swapOut;
   wire [7:0] xorOut;
   wire byteZero;
   wire bitZero;
   wire xorZero;
   wire take;
   wire skipHit;
   wire tableDone;
   wire useLit;
   wire [`PAGE_W-1:0] tablePage;

   // True for either table-read opcode
   function isTableOp;
      input [3:0] op;
      begin
         isTableOp = (op == `OP_TRD_CUR) || (op == `OP_TRD_LAST);
      end
   endfunction

   // True when a skip opcode finds its operand zero
   function skipFires;
      input [3:0] op;
      input byteZ;
      input bitZ;
      begin
         case (op)
            `OP_SKZ: skipFires = byteZ;
            `OP_SKZA: skipFires = byteZ;
            `OP_SKZBIT: skipFires = bitZ;
            default: skipFires = 1'b0;
         endcase
      end
   endfunction

   // True for the three opcodes that write the zero flag
   function isXorOp;
      input [3:0] op;
      begin
         case (op)
            `OP_XOR_TO_ACCUM: isXorOp = 1'b1;
            `OP_XOR_MEM: isXorOp = 1'b1;
            `OP_XOR_IMM: isXorOp = 1'b1;
            default: isXorOp = 1'b0;
         endcase
      end
   endfunction

   // Requests are only taken in idle; a request while busy is dropped
   assign take = instValid && (state_reg == ST_IDLE);
   assign skipHit = take && skipFires(opSel, byteZero, bitZero);
   assign tableDone = (state_reg == ST_TABLE) && progValid;
   assign useLit = (opSel == `OP_XOR_IMM);
   // Last-page read ignores the current page
   assign tablePage = (opSel == `OP_TRD_LAST) ? `LAST_PAGE : curPage;

   // Shared data path
   alu_xor_swap u_alu_xor_swap (
      .accIn(accumulator),
      .memIn(memData),
      .litIn(literal),
      .useLit(useLit),
      .bitSel(bitSel),
      .swapOut(swapOut),
      .xorOut(xorOut),
      .byteZero(byteZero),
      .bitZero(bitZero),
      .xorZero(xorZero)
   );

   // Next-state selection
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (skipHit) begin
               state_next = ST_DUMMY;
            end else if (take && isTableOp(opSel)) begin
               state_next = ST_TABLE;
            end
         end
         ST_DUMMY: begin
            state_next = ST_IDLE;
         end
         ST_TABLE: begin
            if (progValid) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State register and busy level
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         busy <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy <= (state_next != ST_IDLE);
      end
   end

   // Accumulator; the dummy cycle never reaches here since take is low
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         accumulator <= `ZERO_BYTE;
      end else if (take) begin
         case (opSel)
            `OP_SWAP_NIB: accumulator <= swapOut;
            `OP_SKZA: accumulator <= memData;
            `OP_XOR_TO_ACCUM: accumulator <= xorOut;
            `OP_XOR_IMM: accumulator <= xorOut;
            default: accumulator <= accumulator;
         endcase
      end
   end

   // Zero flag, written only by the exclusive-OR group
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         zeroFlag <= 1'b0;
      end else if (take && isXorOp(opSel)) begin
         zeroFlag <= xorZero;
      end
   end

   // Data memory write pulse and its byte
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         memWrite <= 1'b0;
         memWdata <= `ZERO_BYTE;
      end else begin
         memWrite <= 1'b0;
         if (take && (opSel == `OP_XOR_MEM)) begin
            memWrite <= 1'b1;
            memWdata <= xorOut;
         end else if (tableDone) begin
            memWrite <= 1'b1;
            memWdata <= progWord[`LOW_BYTE];
         end
      end
   end

   // High part of a fetched table word
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         table_high_latch <= `ZERO_HIGH;
      end else if (tableDone) begin
         table_high_latch <= progWord[`HIGH_PART];
      end
   end

   // Program memory request; address holds until the next table read
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         progRead <= 1'b0;
         progAddr <= `ZERO_ADDR;
      end else begin
         progRead <= 1'b0;
         if (take && isTableOp(opSel)) begin
            progRead <= 1'b1;
            progAddr <= {tablePage, table_pointer};
         end
      end
   end

   // One-cycle order to drop the prefetched instruction
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         discardFetch <= 1'b0;
      end else begin
         discardFetch <= skipHit;
      end
   end
endmodule

// *** testbench/exec_unit_properties.sv ***
// Checker for the execution unit outputs
`timescale 1ns/1ns
module exec_unit_properties (
   input wire mclk,
   input wire sys_rst,
   input wire instValid,
   input wire [3:0] opSel,
   input wire [7:0] memData,
   input wire [7:0] literal,
   input wire [2:0] bitSel,
   input wire [14:0] progWord,
   input wire progValid,
   input wire [7:0] accumulator,
   input wire [6:0] table_high_latch,
   input wire zeroFlag,
   input wire memWrite,
   input wire [7:0] memWdata,
   input wire discardFetch,
   input wire busy
);
   // Taken request and selected bit
   wire tk = instValid && !busy;
   wire selBit = memData[bitSel];
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   swap_result_a: assert property (tk && opSel == 4'h1 |=>
      accumulator == {$past(memData[3:0]), $past(memData[7:4])} && $stable(zeroFlag))
      else $error("bad swap");
   byte_skip_a: assert property (tk && opSel == 4'h2 |=>
      discardFetch == ($past(memData) == 8'h00)) else $error("bad skip");
   copy_skip_a: assert property (tk && opSel == 4'h3 |=>
      accumulator == $past(memData) && discardFetch == (accumulator == 8'h00)) else $error("bad copy");
   bit_skip_a: assert property (tk && opSel == 4'h4 |=>
      discardFetch == !$past(selBit)) else $error("bad bit skip");
   dummy_nop_a: assert property (discardFetch |-> busy ##1
      (!busy && $stable(accumulator) && $stable(zeroFlag))) else $error("bad dummy");
   table_load_a: assert property (busy && progValid && !discardFetch |=>
      memWrite && {table_high_latch, memWdata} == $past(progWord)) else $error("bad table");
   xor_acc_a: assert property (tk && opSel == 4'h7 |=>
      zeroFlag == (accumulator == 8'h00)) else $error("bad zero");
   xor_mem_a: assert property (tk && opSel == 4'h8 |=> memWrite &&
      memWdata == ($past(accumulator) ^ $past(memData))) else $error("bad xor");
   xor_imm_a: assert property (tk && opSel == 4'h9 |=>
      accumulator == ($past(accumulator) ^ $past(literal)) && zeroFlag == (accumulator == 8'h00))
      else $error("bad immediate xor");
endmodule
bind skip_swap_tableread_xor_exec exec_unit_properties u_exec_unit_properties (.mclk, .sys_rst,
   .instValid, .opSel, .memData, .literal, .bitSel, .progWord, .progValid, .accumulator,
   .table_high_latch, .zeroFlag, .memWrite, .memWdata, .discardFetch, .busy);

// *** testbench/tb_skip_swap_tableread_xor_exec.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/1ns
module tb_skip_swap_tableread_xor_exec;
   reg mclk = 1'b0, sys_rst = 1'b1, instValid = 1'b0, progValid = 1'b0;
   reg [3:0] opSel = 4'h0, curPage = 4'h3;
   reg [7:0] memData = 8'h00, literal = 8'h0f, table_pointer = 8'h5a;
   reg [2:0] bitSel = 3'h7;
   reg [14:0] progWord = 15'h7e81;
   wire [7:0] accumulator, memWdata;
   wire [6:0] table_high_latch;
   wire [11:0] progAddr;
   wire zeroFlag, memWrite, progRead, discardFetch, busy;
   integer failures = 0, compares = 0;
   skip_swap_tableread_xor_exec u_skip_swap_tableread_xor_exec (.mclk, .sys_rst, .instValid,
      .opSel, .memData, .literal, .bitSel, .table_pointer, .curPage, .progWord, .progValid,
      .accumulator, .table_high_latch, .zeroFlag, .memWrite, .memWdata, .progRead,
      .progAddr, .discardFetch, .busy);
   task chk(input [16:0] got, input [16:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         if (failures == 0 && compares > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // One instruction, held for one taking edge
   task issue(input [3:0] op, input [7:0] m);
      integer i;
      begin
         @(negedge mclk);
         for (i = 0; i < 9 && busy !== 1'b0; i = i + 1) @(negedge mclk);
         if (busy !== 1'b0) begin
            failures = failures + 1;
            give_verdict;
         end
         opSel = op;
         memData = m;
         instValid = 1'b1;
         @(negedge mclk);
         instValid = 1'b0;
      end
   endtask
   initial begin
      forever #25 mclk = ~mclk;
   end
   // Swap leaves the zero flag alone
   task run_swap;
      begin
         issue(4'h1, 8'h3c);
         chk({zeroFlag, accumulator}, 9'h0c3);
      end
   endtask
   // Byte skip taken, its dummy cycle, then not taken
   task run_byte_skip;
      begin
         issue(4'h2, 8'h00);
         chk({discardFetch, busy, accumulator}, 10'h3c3);
         @(negedge mclk);
         chk({discardFetch, busy, memWrite, accumulator}, 11'h0c3);
         issue(4'h2, 8'h01);
         chk({discardFetch, busy}, 2'h0);
      end
   endtask
   // Copy-and-skip with zero and nonzero bytes
   task run_copy_skip;
      begin
         issue(4'h3, 8'h00);
         chk({discardFetch, accumulator}, 9'h100);
         issue(4'h3, 8'h5a);
         chk({discardFetch, busy, accumulator}, 10'h05a);
      end
   endtask
   // Bit skip on bit 7 clear and set
   task run_bit_skip;
      begin
         issue(4'h4, 8'h7f);
         chk(discardFetch, 1'b1);
         issue(4'h4, 8'h80);
         chk({discardFetch, busy}, 2'h0);
      end
   endtask
   // One table read with its memory answer
   task run_table(input [3:0] op, input [11:0] addr);
      begin
         issue(op, 8'h00);
         chk({progRead, busy, progAddr}, {2'h3, addr});
         progValid = 1'b1;
         @(negedge mclk);
         progValid = 1'b0;
         chk({busy, memWrite, table_high_latch, memWdata}, 17'h0fe81);
      end
   endtask
   // The three exclusive-OR forms
   task run_xor;
      begin
         issue(4'h3, 8'h5a);
         issue(4'h7, 8'h5a);
         chk({zeroFlag, accumulator}, 9'h100);
         issue(4'h9, 8'h00);
         chk({zeroFlag, accumulator}, 9'h00f);
         issue(4'h8, 8'hf0);
         chk({memWrite, memWdata, accumulator}, 17'h1ff0f);
         chk(zeroFlag, 1'b0);
      end
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      run_swap;
      run_byte_skip;
      run_copy_skip;
      run_bit_skip;
      run_table(4'h5, 12'h35a);
      run_table(4'h6, 12'hf5a);
      run_xor;
      give_verdict;
   end
endmodule
